// ==== pdw_pkg.sv ====
// Purpose: constants for the power-down, wake-up and reset-cause block
// Assumes: 10 MHz mclk, APB register access
// Notes: offsets are byte addresses of aligned 32-bit words
package pdw_pkg;
  // ==========================================================
  // register map
  localparam logic [11:0] PDW_OFS_RSTFLAGS = 12'h000;
  localparam logic [11:0] PDW_OFS_WAKEEN = 12'h004;
  localparam logic [11:0] PDW_OFS_PULLA = 12'h008;
  localparam logic [11:0] PDW_OFS_PULLB = 12'h00c;
  localparam logic [11:0] PDW_OFS_WDTCTL = 12'h010;
  localparam logic [11:0] PDW_OFS_LVCTL = 12'h014;
  localparam logic [11:0] PDW_OFS_STATUS = 12'h018;
  localparam logic [11:0] PDW_OFS_CONFIG = 12'h01c;
  // ==========================================================
  // field positions
  localparam int PDW_BIT_LOW_VOLTAGE_RESET_FLAG = 2;
  localparam int PDW_BIT_LCRF = 1;
  localparam int PDW_BIT_WCRF = 0;
  localparam int PDW_BIT_TOF = 5;
  localparam int PDW_BIT_PDF = 4;
  localparam int PDW_BIT_SLEEP = 0;
  localparam int PDW_BIT_XTAL = 0;
  // ==========================================================
  // reset values and codes
  localparam logic [7:0] PDW_RST_WDTCTL = 8'h53;
  localparam logic [4:0] PDW_WE_DISABLE = 5'h15;
  localparam logic [4:0] PDW_WE_ENABLE = 5'h0a;
  localparam logic [7:0] PDW_RST_PULL = 8'h00;
  localparam logic [7:0] PDW_RST_WAKE = 8'h00;
  localparam logic [7:0] PDW_RST_LVCTL = 8'h00;
  // ==========================================================
  // timing
  localparam int PDW_CLK_HZ = 10000000;
  localparam int PDW_SST1_CYC = 2;
  localparam int PDW_SST2_CYC = 1024;
  localparam int PDW_RSTD_MS = 50;
  localparam int PDW_RSTD_CYC = PDW_RSTD_MS * (PDW_CLK_HZ / 1000);
  localparam int PDW_WCR_INTERNAL_SLOW_OSC_CYC = 2;
  typedef enum logic [1:0] {PDW_RUN, PDW_SLEEP, PDW_WAKEWAIT} pdw_state_e;
endpackage : pdw_pkg

// ==== pdw_core.sv ====
// Purpose: power-down entry, wake-up delay and reset-cause flags
// Assumes: one mclk domain; pins and slow oscillator tick come from outside
// Notes: mclk is modelled as gated by the sleep state, not truly stopped
//
// How it works
// - reset-cause bits seven to three always read zero.
// - low-voltage reset flag set by low-voltage event, software clears.
// - voltage-control flag set on undefined control value, software clears.
// - watchdog-control flag set on bad watchdog code, software clears.
// - wake-enable register picks port A pins whose falling edge wakes.
// - pull-high select registers drive per-pin pull-high enables.
// - in sleep system clock stops; slow oscillator keeps watchdog running.
// - only the stop instruction enters sleep and halts execution.
// - registers and ports keep their values on sleep entry.
// - watchdog counter cleared at sleep entry, then resumes if enabled.
// - stop instruction sets power-down flag, clears timeout flag.
// - wake on enabled pin falling edge, interrupt or watchdog overflow.
// - power-up or clear-watchdog clears power-down flag; stop sets it.
// - watchdog timeout in sleep sets timeout flag, resets pc and sp only.
// - pin wake resumes after the stop instruction.
// - disabled or stack-full interrupt wake resumes after stop, stays pending.
// - enabled interrupt with free stack takes normal interrupt response.
// - interrupt already pending before sleep does not wake.
// - wake waits 2 clocks on fast oscillator, 1024 on crystal.
// - power-on or low-voltage wake waits reset delay plus 1024 cycles.
// - bad watchdog code resets on the second slow edge, one to two slow cycles later, sets flag.
// - status writes never alter timeout or power-down flags.
`timescale 1ns/1ps
module pdw_core
  import pdw_pkg::*;
#(
  parameter int RSTD_CYC = PDW_RSTD_CYC,
  parameter int NPINS = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu events
  input wire logic stopInstr,
  input wire logic clrWdtInstr,
  input wire logic [7:0] irqReq,
  input wire logic [7:0] irqEnable,
  input wire logic stackFull,
  // supervision events and pins
  input wire logic lowVoltageEvt,
  input wire logic wdtOverflow,
  input wire logic slowOscTick,
  input wire logic [NPINS-1:0] portAPins,
  // outputs
  output logic cpuRun,
  output logic sysClkEnable,
  output logic wdtClear,
  output logic pcSpReset,
  output logic irqTakeOnWake,
  output logic resumeNext,
  output logic sysResetReq,
  output logic [NPINS-1:0] pullAEnable,
  output logic [7:0] pullBEnable,
  output logic [4:0] wdtEnableField,
  output logic [2:0] wdtPeriodSel
);
  initial begin
    if (NPINS < 1 || NPINS > 8) $error("NPINS must be 1..8");
    if (RSTD_CYC < 1) $error("RSTD_CYC must be positive");
  end

  localparam int WCW = $clog2(RSTD_CYC + PDW_SST2_CYC + 1);

  // ==========================================================
  // apb slave, zero wait states
  logic [7:0] wakeEn_r;
  logic [7:0] pullA_r;
  logic [7:0] pullB_r;
  logic [7:0] wdtCtl_r;
  logic [7:0] lvCtl_r;
  logic xtalSel_r;
  logic low_voltage_reset_flag_r;
  logic lcrf_r;
  logic wcrf_r;
  logic pdf_r;
  logic tof_r;
  pdw_state_e state_r;
  logic [WCW-1:0] waitCnt_r;

  logic wrAcc;
  assign wrAcc = psel & penable & pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction : hit

  function automatic logic lvDefined(input logic [7:0] v);
    // only a few threshold codes are valid; others act as a software reset
    lvDefined = (v == 8'h00) || (v == 8'h33) || (v == 8'h99) || (v == 8'haa);
  endfunction : lvDefined

  logic mapped;
  assign mapped = hit(paddr, PDW_OFS_RSTFLAGS) | hit(paddr, PDW_OFS_WAKEEN) | hit(paddr, PDW_OFS_PULLA) |
                  hit(paddr, PDW_OFS_PULLB) | hit(paddr, PDW_OFS_WDTCTL) | hit(paddr, PDW_OFS_LVCTL) |
                  hit(paddr, PDW_OFS_STATUS) | hit(paddr, PDW_OFS_CONFIG);

  // read mux, registered below so prdata comes straight from a flip-flop
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    case (paddr[11:2])
      PDW_OFS_RSTFLAGS[11:2]: rdMux = {29'h0, low_voltage_reset_flag_r, lcrf_r, wcrf_r};
      PDW_OFS_WAKEEN[11:2]: rdMux = {24'h0, wakeEn_r};
      PDW_OFS_PULLA[11:2]: rdMux = {24'h0, pullA_r};
      PDW_OFS_PULLB[11:2]: rdMux = {24'h0, pullB_r};
      PDW_OFS_WDTCTL[11:2]: rdMux = {24'h0, wdtCtl_r};
      PDW_OFS_LVCTL[11:2]: rdMux = {24'h0, lvCtl_r};
      PDW_OFS_STATUS[11:2]: rdMux = {26'h0, tof_r, pdf_r, 3'h0, state_r != PDW_RUN};
      PDW_OFS_CONFIG[11:2]: rdMux = {31'h0, xtalSel_r};
      default: rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0;
      if (psel & ~penable & ~pwrite) prdata <= rdMux;
    end
  end

  logic wrStrobe;
  // write takes effect in the access cycle, pready is high there
  assign wrStrobe = wrAcc & pready & ~pslverr;

  // ==========================================================
  // configuration registers, untouched by sleep entry
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wakeEn_r <= PDW_RST_WAKE;
      pullA_r <= PDW_RST_PULL;
      pullB_r <= PDW_RST_PULL;
      wdtCtl_r <= PDW_RST_WDTCTL;
      lvCtl_r <= PDW_RST_LVCTL;
      xtalSel_r <= 1'b0;
    end else if (wrStrobe) begin
      if (hit(paddr, PDW_OFS_WAKEEN)) wakeEn_r <= pwdata[7:0];
      if (hit(paddr, PDW_OFS_PULLA)) pullA_r <= pwdata[7:0];
      if (hit(paddr, PDW_OFS_PULLB)) pullB_r <= pwdata[7:0];
      if (hit(paddr, PDW_OFS_WDTCTL)) wdtCtl_r <= pwdata[7:0];
      if (hit(paddr, PDW_OFS_LVCTL)) lvCtl_r <= pwdata[7:0];
      if (hit(paddr, PDW_OFS_CONFIG)) xtalSel_r <= pwdata[PDW_BIT_XTAL];
    end
  end

  // ==========================================================
  // pin synchronisers: a level counts once stages two and three agree
  logic [NPINS-1:0] pinFall;
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
          lvl_r <= 1'b1;
        end else begin
          s1_r <= portAPins[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) lvl_r <= s2_r;
        end
      end
      // accepted level starts high like the idle pin, so release gives no false edge
      assign pinFall[gi] = lvl_r & ~s2_r & ~s3_r;
    end
  endgenerate
  logic pinWake;
  assign pinWake = |(pinFall & wakeEn_r[NPINS-1:0]);

  // ==========================================================
  // slow oscillator tick sync, bad watchdog code reset
  logic tkS1_r;
  logic tkS2_r;
  logic tkS3_r;
  logic slowLvl_r;
  logic [1:0] wcrCnt_r;
  logic wdtBad;
  logic slowEdge;
  assign wdtBad = (wdtCtl_r[7:3] != PDW_WE_DISABLE) && (wdtCtl_r[7:3] != PDW_WE_ENABLE);
  // rising edge of the accepted level, immune to a one-stage glitch
  assign slowEdge = tkS2_r & tkS3_r & ~slowLvl_r;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tkS1_r <= 1'b0;
      tkS2_r <= 1'b0;
      tkS3_r <= 1'b0;
      slowLvl_r <= 1'b0;
      wcrCnt_r <= 2'h0;
    end else begin
      tkS1_r <= slowOscTick;
      tkS2_r <= tkS1_r;
      tkS3_r <= tkS2_r;
      if (tkS2_r == tkS3_r) slowLvl_r <= tkS2_r;
      if (!wdtBad) wcrCnt_r <= 2'h0;
      else if (slowEdge && wcrCnt_r != 2'(PDW_WCR_INTERNAL_SLOW_OSC_CYC)) wcrCnt_r <= wcrCnt_r + 2'h1;
    end
  end
  logic wcrFire;
  assign wcrFire = wdtBad && slowEdge && wcrCnt_r == 2'(PDW_WCR_INTERNAL_SLOW_OSC_CYC - 1);

  // ==========================================================
  // reset-cause flags: set beats clear, write of one keeps value
  logic flagWr;
  assign flagWr = wrStrobe & hit(paddr, PDW_OFS_RSTFLAGS);
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      low_voltage_reset_flag_r <= 1'b0;
      lcrf_r <= 1'b0;
      wcrf_r <= 1'b0;
    end else begin
      if (lowVoltageEvt) low_voltage_reset_flag_r <= 1'b1;
      else if (flagWr && !pwdata[PDW_BIT_LOW_VOLTAGE_RESET_FLAG]) low_voltage_reset_flag_r <= 1'b0;
      if (!lvDefined(lvCtl_r)) lcrf_r <= 1'b1;
      else if (flagWr && !pwdata[PDW_BIT_LCRF]) lcrf_r <= 1'b0;
      if (wcrFire) wcrf_r <= 1'b1;
      else if (flagWr && !pwdata[PDW_BIT_WCRF]) wcrf_r <= 1'b0;
    end
  end

  // ==========================================================
  // power-down and timeout flags, ignore status writes
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pdf_r <= 1'b0;
      tof_r <= 1'b0;
    end else begin
      if (state_r == PDW_RUN && stopInstr) begin
        pdf_r <= 1'b1;
        tof_r <= 1'b0;
      end else if (state_r == PDW_RUN && clrWdtInstr) begin
        pdf_r <= 1'b0;
        tof_r <= 1'b0;
      end
      if (wdtOverflow) tof_r <= 1'b1;
    end
  end

  // ==========================================================
  // sleep state machine and wake delay
  logic [7:0] irqMask_r;
  logic [7:0] irqFresh;
  logic anyIrqWake;
  logic enIrqWake;
  assign irqFresh = irqReq & ~irqMask_r;
  assign anyIrqWake = |irqFresh;
  assign enIrqWake = |(irqFresh & irqEnable);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= PDW_WAKEWAIT;
      waitCnt_r <= WCW'(RSTD_CYC + PDW_SST2_CYC);
      irqMask_r <= 8'h00;
      cpuRun <= 1'b0;
      sysClkEnable <= 1'b1;
      wdtClear <= 1'b0;
      pcSpReset <= 1'b0;
      irqTakeOnWake <= 1'b0;
      resumeNext <= 1'b0;
      sysResetReq <= 1'b0;
    end else begin
      wdtClear <= 1'b0;
      pcSpReset <= 1'b0;
      irqTakeOnWake <= 1'b0;
      resumeNext <= 1'b0;
      sysResetReq <= wcrFire | (lcrf_r == 1'b0 && !lvDefined(lvCtl_r));
      case (state_r)
        PDW_RUN: begin
          if (stopInstr) begin
            state_r <= PDW_SLEEP;
            cpuRun <= 1'b0;
            sysClkEnable <= 1'b0;
            wdtClear <= 1'b1;
            irqMask_r <= irqReq;
          end
        end
        PDW_SLEEP: begin
          if (pinWake || anyIrqWake || wdtOverflow) begin
            state_r <= PDW_WAKEWAIT;
            sysClkEnable <= 1'b1;
            waitCnt_r <= xtalSel_r ? WCW'(PDW_SST2_CYC) : WCW'(PDW_SST1_CYC);
            pcSpReset <= wdtOverflow;
            irqTakeOnWake <= !wdtOverflow && enIrqWake && !stackFull;
            resumeNext <= !wdtOverflow && !(enIrqWake && !stackFull);
          end
        end
        PDW_WAKEWAIT: begin
          if (waitCnt_r <= WCW'(1)) begin
            state_r <= PDW_RUN;
            cpuRun <= 1'b1;
          end else begin
            waitCnt_r <= waitCnt_r - WCW'(1);
          end
        end
        default: state_r <= PDW_RUN;
      endcase
      // a low-voltage reset restarts the full reset delay from any state
      if (lowVoltageEvt) begin
        state_r <= PDW_WAKEWAIT;
        waitCnt_r <= WCW'(RSTD_CYC + PDW_SST2_CYC);
        cpuRun <= 1'b0;
        sysClkEnable <= 1'b1;
      end
    end
  end

  // ==========================================================
  // registered configuration outputs
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pullAEnable <= '0;
      pullBEnable <= 8'h00;
      wdtEnableField <= PDW_RST_WDTCTL[7:3];
      wdtPeriodSel <= PDW_RST_WDTCTL[2:0];
    end else begin
      pullAEnable <= pullA_r[NPINS-1:0];
      pullBEnable <= pullB_r;
      wdtEnableField <= wdtCtl_r[7:3];
      wdtPeriodSel <= wdtCtl_r[2:0];
    end
  end
endmodule : pdw_core

// ==== pdw_core_checker.sv ====
// Purpose: port assertions for pdw_core
// Assumes: one mclk domain, synchronous active-low reset
// Notes: registered pulses get a two-cycle window
`timescale 1ns/1ps
module pdw_core_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // cpu and wake
  input wire logic stopInstr,
  input wire logic wdtOverflow,
  input wire logic cpuRun,
  input wire logic sysClkEnable,
  input wire logic wdtClear,
  input wire logic pcSpReset,
  input wire logic irqTakeOnWake,
  input wire logic resumeNext
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ====
  // sequences
  sequence stopTaken;
    cpuRun && stopInstr;
  endsequence
  sequence asleep;
    !cpuRun && !sysClkEnable;
  endsequence
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_err_pair: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_flag_zero: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[7:3] == 5'h00)
    else $error("upper flag bits not zero");
  chk_stop_enter: assert property (stopTaken |-> ##[1:2] asleep)
    else $error("stop did not halt");
  chk_stop_wdtclr: assert property (stopTaken |-> ##[1:2] wdtClear)
    else $error("no watchdog clear on stop");
  chk_wdt_wake: assert property (asleep ##0 wdtOverflow |-> ##[1:2] pcSpReset)
    else $error("watchdog wake without pc reset");
  chk_wake_excl: assert property (irqTakeOnWake |-> !resumeNext && !pcSpReset)
    else $error("two wake responses at once");
  chk_run_clock: assert property (cpuRun |-> sysClkEnable)
    else $error("running with clock off");
endmodule : pdw_core_checker
bind pdw_core pdw_core_checker u_chk (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stopInstr(stopInstr), .wdtOverflow(wdtOverflow), .cpuRun(cpuRun), .sysClkEnable(sysClkEnable),
  .wdtClear(wdtClear), .pcSpReset(pcSpReset), .irqTakeOnWake(irqTakeOnWake), .resumeNext(resumeNext));

// ==== pdw_wake_src.sv ====
// Purpose: wake sources and slow oscillator beside pdw_core
// Assumes: pins idle high through their pull-ups
// Notes: slow clock phase is unrelated to mclk
`timescale 1ns/1ps
module pdw_wake_src (
  // clock
  input wire logic mclk,
  // sources
  output logic [7:0] portAPins,
  output logic [7:0] irqReq,
  output logic wdtOverflow,
  output logic lowVoltageEvt,
  output logic slowOscTick
);
  initial begin
    portAPins = 8'hff;
    irqReq = 8'h00;
    wdtOverflow = 1'h0;
    lowVoltageEvt = 1'h0;
    slowOscTick = 1'h0;
  end
  // free-running, also while the core sleeps
  always #15625 slowOscTick = ~slowOscTick;
  task automatic fall_pin(input int k);
    @(posedge mclk);
    portAPins[k] <= 1'h0;
  endtask : fall_pin
  task automatic pins_idle;
    @(posedge mclk);
    portAPins <= 8'hff;
  endtask : pins_idle
  task automatic raise_irq(input int k);
    @(posedge mclk);
    irqReq[k] <= 1'h1;
  endtask : raise_irq
  task automatic pulse_wdt;
    @(posedge mclk);
    wdtOverflow <= 1'h1;
    @(posedge mclk);
    wdtOverflow <= 1'h0;
  endtask : pulse_wdt
  task automatic pulse_lv;
    @(posedge mclk);
    lowVoltageEvt <= 1'h1;
    @(posedge mclk);
    lowVoltageEvt <= 1'h0;
  endtask : pulse_lv
endmodule : pdw_wake_src

// ==== pdw_core_tb.sv ====
// Purpose: self-checking bench for pdw_core
// Assumes: short reset delay parameter
// Notes: pulses are counted by a monitor
`timescale 1ns/1ps
module pdw_core_tb;
  import pdw_pkg::*;
  localparam int RSTD = 20;
  logic mclk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic stopInstr = 1'h0, clrWdtInstr = 1'h0, stackFull = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] irqEnable = 8'h00, portAPins, irqReq, pullAEnable, pullBEnable;
  logic pready, pslverr, lowVoltageEvt, wdtOverflow, slowOscTick, cpuRun, sysClkEnable;
  logic wdtClear, pcSpReset, irqTakeOnWake, resumeNext, sysResetReq;
  logic [4:0] wdtEnableField;
  logic [2:0] wdtPeriodSel;
  int fails = 0, checked = 0, nWdt = 0, nIrq = 0, nRes = 0, nSys = 0;
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    nWdt += int'(pcSpReset === 1'h1);
    nIrq += int'(irqTakeOnWake === 1'h1);
    nRes += int'(resumeNext === 1'h1);
    nSys += int'(sysResetReq === 1'h1);
  end
  pdw_core #(.RSTD_CYC(RSTD)) i_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stopInstr(stopInstr), .clrWdtInstr(clrWdtInstr), .irqReq(irqReq), .irqEnable(irqEnable),
    .stackFull(stackFull), .lowVoltageEvt(lowVoltageEvt), .wdtOverflow(wdtOverflow),
    .slowOscTick(slowOscTick), .portAPins(portAPins), .cpuRun(cpuRun), .sysClkEnable(sysClkEnable),
    .wdtClear(wdtClear), .pcSpReset(pcSpReset), .irqTakeOnWake(irqTakeOnWake), .resumeNext(resumeNext),
    .sysResetReq(sysResetReq), .pullAEnable(pullAEnable), .pullBEnable(pullBEnable),
    .wdtEnableField(wdtEnableField), .wdtPeriodSel(wdtPeriodSel));
  pdw_wake_src i_src (.mclk(mclk), .portAPins(portAPins), .irqReq(irqReq), .wdtOverflow(wdtOverflow),
    .lowVoltageEvt(lowVoltageEvt), .slowOscTick(slowOscTick));
  // ====
  // helpers
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1 && n++ < 50);
    if (pready !== 1'h1) fails++;
    r = {pslverr, prdata};
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [32:0] r;
    apb(1'h0, a, 32'h0, r);
    cmp(r, {1'h0, x});
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'h1, a, d, r);
  endtask : wr
  task automatic waitrun(output int n);
    n = 0;
    while (cpuRun !== 1'h1 && n < 3000) begin
      @(posedge mclk) #1;
      n++;
    end
  endtask : waitrun
  task automatic go_sleep;
    int n;
    waitrun(n);
    @(posedge mclk);
    stopInstr <= 1'h1;
    @(posedge mclk);
    stopInstr <= 1'h0;
    repeat (6) @(posedge mclk);
    cmp({cpuRun, sysClkEnable}, 2'h0);
  endtask : go_sleep
  // ====
  // scenarios
  task automatic t_boot;
    int n;
    repeat (8) @(posedge mclk);
    rst_b <= 1'h1;
    waitrun(n);
    cmp(n inside {[RSTD + PDW_SST2_CYC - 1:RSTD + PDW_SST2_CYC + 3]}, 1'h1);
    rd(PDW_OFS_WDTCTL, {24'h0, PDW_RST_WDTCTL});
  endtask : t_boot
  task automatic t_regs;
    logic [32:0] r;
    wr(PDW_OFS_PULLA, 32'ha5);
    wr(PDW_OFS_PULLB, 32'h3c);
    repeat (2) @(posedge mclk);
    cmp({pullBEnable, pullAEnable}, 16'h3ca5);
    wr(PDW_OFS_STATUS, 32'hff);
    rd(PDW_OFS_STATUS, 32'h0);
    apb(1'h0, 12'h040, 32'h0, r);
    cmp(r, 33'h100000000);
  endtask : t_regs
  task automatic t_flags;
    int n;
    rd(PDW_OFS_RSTFLAGS, 32'h0);
    i_src.pulse_lv();
    rd(PDW_OFS_RSTFLAGS, 32'h4);
    waitrun(n);
    cmp(n inside {[RSTD + PDW_SST2_CYC - 6:RSTD + PDW_SST2_CYC + 3]}, 1'h1);
    wr(PDW_OFS_RSTFLAGS, 32'hff);
    rd(PDW_OFS_RSTFLAGS, 32'h4);
    wr(PDW_OFS_RSTFLAGS, 32'h0);
    rd(PDW_OFS_RSTFLAGS, 32'h0);
    wr(PDW_OFS_LVCTL, 32'h55);
    rd(PDW_OFS_RSTFLAGS, 32'h2);
    wr(PDW_OFS_LVCTL, 32'h33);
    wr(PDW_OFS_RSTFLAGS, 32'h0);
    wr(PDW_OFS_WDTCTL, 32'hff);
    repeat (1200) @(posedge mclk);
    rd(PDW_OFS_RSTFLAGS, 32'h1);
    cmp(nSys > 1, 1'h1);
    wr(PDW_OFS_WDTCTL, 32'h53);
    wr(PDW_OFS_RSTFLAGS, 32'h0);
  endtask : t_flags
  task automatic t_sleep;
    int n, c;
    wr(PDW_OFS_WAKEEN, 32'h01);
    wr(PDW_OFS_CONFIG, 32'h0);
    go_sleep();
    c = nRes;
    i_src.fall_pin(1);
    repeat (10) @(posedge mclk);
    cmp(cpuRun, 1'h0);
    i_src.fall_pin(0);
    waitrun(n);
    cmp(n inside {[3:12]}, 1'h1);
    cmp(nRes - c, 1);
    i_src.pins_idle();
    rd(PDW_OFS_STATUS, 32'h10);
    rd(PDW_OFS_PULLA, 32'ha5);
    irqEnable <= 8'hff;
    go_sleep();
    c = nIrq;
    i_src.raise_irq(0);
    waitrun(n);
    cmp(nIrq - c, 1);
    stackFull <= 1'h1;
    go_sleep();
    c = nRes;
    i_src.raise_irq(2);
    waitrun(n);
    cmp(nRes - c, 1);
    go_sleep();
    repeat (30) @(posedge mclk);
    cmp(cpuRun, 1'h0);
    c = nWdt;
    i_src.pulse_wdt();
    waitrun(n);
    cmp(nWdt - c, 1);
    rd(PDW_OFS_STATUS, 32'h30);
    clrWdtInstr <= 1'h1;
    @(posedge mclk);
    clrWdtInstr <= 1'h0;
    rd(PDW_OFS_STATUS, 32'h0);
    wr(PDW_OFS_CONFIG, 32'h1);
    go_sleep();
    i_src.pulse_wdt();
    waitrun(n);
    cmp(n inside {[PDW_SST2_CYC:PDW_SST2_CYC + 6]}, 1'h1);
  endtask : t_sleep
  task automatic report_and_stop;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    t_boot();
    t_regs();
    t_flags();
    t_sleep();
    report_and_stop();
  end
  // about six times the expected run
  initial begin
    #3000000;
    fails++;
    report_and_stop();
  end
endmodule : pdw_core_tb
